// ==== inc/cpd_pkg.sv ====
// constants, opcode classes and carriers shared by the control and pointer decoder
package cpd_pkg;

    // full opcodes of the fixed-encoding instructions
    localparam logic [13:0] OPC_NOP    = 14'h0000;
    localparam logic [13:0] OPC_SWRST  = 14'h0001;
    localparam logic [13:0] OPC_RET    = 14'h0008;
    localparam logic [13:0] OPC_RETI   = 14'h0009;
    localparam logic [13:0] OPC_SUBROUTINE_JUMP_BY_ACCUM  = 14'h000a;
    localparam logic [13:0] OPC_BRW    = 14'h000b;
    localparam logic [13:0] OPC_OPTION = 14'h0062;
    localparam logic [13:0] OPC_SLEEP  = 14'h0063;
    localparam logic [13:0] OPC_WDTCLR = 14'h0064;

    // opcode prefixes, matched against the top bits of the word
    localparam logic [9:0]  PFX_IND    = 10'h001;
    localparam logic [10:0] PFX_PIN_DIRECTION_LOAD   = 11'h00c;
    localparam logic [6:0]  PFX_PADD   = 7'h62;
    localparam logic [5:0]  PFX_IDX    = 6'h3f;
    localparam logic [5:0]  PFX_RETURN_LOADING_LITERAL  = 6'h34;
    localparam logic [5:0]  PFX_AND_LITERAL_ACCUM  = 6'h39;
    localparam logic [5:0]  PFX_ADD_LITERAL_ACCUM  = 6'h3e;
    localparam logic [5:0]  PFX_AND_ACCUM_FILE  = 6'h05;
    localparam logic [4:0]  PFX_BRA    = 5'h19;
    localparam logic [2:0]  PFX_CALL   = 3'h4;
    localparam logic [2:0]  PFX_GOTO   = 3'h5;

    // file addresses that alias the indirect data ports
    localparam logic [6:0]  FILE_IND0  = 7'h00;
    localparam logic [6:0]  FILE_IND1  = 7'h01;

    // pointer_update_mode encodings
    localparam logic [1:0]  MM_PREINC  = 2'h0;
    localparam logic [1:0]  MM_PREDEC  = 2'h1;
    localparam logic [1:0]  MM_POSTINC = 2'h2;
    localparam logic [1:0]  MM_POSTDEC = 2'h3;

    // values after reset
    localparam logic [14:0] PC_RST     = 15'h0000;
    localparam logic [15:0] FSR_RST    = 16'h0000;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [7:0]  OPTION_RST = 8'hff;
    localparam logic [7:0]  PIN_DIRECTION_LOAD_RST   = 8'hff;

    // clocks per instruction cycle
    localparam int unsigned QPHASES    = 4;

    typedef enum logic [4:0] {
        OP_NOP    = 5'b00000,
        OP_SWRST  = 5'b00001,
        OP_RET    = 5'b00010,
        OP_RETI   = 5'b00011,
        OP_SUBROUTINE_JUMP_BY_ACCUM  = 5'b00100,
        OP_BRW    = 5'b00101,
        OP_OPTION = 5'b00110,
        OP_SLEEP  = 5'b00111,
        OP_WDTCLR = 5'b01000,
        OP_PIN_DIRECTION_LOAD   = 5'b01001,
        OP_IND    = 5'b01010,
        OP_PADD   = 5'b01011,
        OP_IDX    = 5'b01100,
        OP_RETURN_LOADING_LITERAL  = 5'b01101,
        OP_AND_LITERAL_ACCUM  = 5'b01110,
        OP_ADD_LITERAL_ACCUM  = 5'b01111,
        OP_AND_ACCUM_FILE  = 5'b10000,
        OP_BRA    = 5'b10001,
        OP_CALL   = 5'b10010,
        OP_GOTO   = 5'b10011,
        OP_OTHER  = 5'b10100
    } cpd_op_t;

    typedef struct packed {
        logic to;
        logic pd;
        logic z;
        logic dc;
        logic c;
    } cpd_status_t;

    localparam cpd_status_t STATUS_RST = 5'b11000;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } cpd_mem_req_t;

endpackage

// ==== src/cpd_qphase.sv ====
// divider that splits the clock into the phases of one instruction cycle
`timescale 1ns/1ns
`default_nettype none
module cpd_qphase import cpd_pkg::*; #(
    parameter int unsigned PHASES = QPHASES
) (
    input  wire logic mclk,    // system clock
    input  wire logic resetn,  // synchronous reset, active low
    output logic      q_first, // first clock of the instruction cycle
    output logic      q_last   // last clock of the instruction cycle
);
    localparam int CW = $clog2(PHASES);
    localparam logic [CW-1:0] LAST = CW'(PHASES - 1);

    logic [CW-1:0] cnt;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

    assign q_first = resetn && (cnt == '0);
    assign q_last  = resetn && (cnt == LAST);
endmodule
`default_nettype wire

// ==== src/cpd_core.sv ====
// control-flow, inherent, pointer and literal instruction decode and execute
`timescale 1ns/1ns
`default_nettype none
module cpd_core import cpd_pkg::*; #(
    parameter int STK_DEPTH = 16,
    parameter int PIN_DIRECTION_LOAD_N    = 8
) (
    input  wire logic           mclk,        // system clock, 250 MHz
    input  wire logic           resetn,      // synchronous reset, active low
    input  wire logic [13:0]    instr_word,  // program memory word at pc
    input  wire logic [6:0]     pc_upper_in, // upper target bits held elsewhere
    input  wire logic [7:0]     mem_rdata,   // data memory read data
    output cpd_mem_req_t        mem,         // data memory request
    output logic [14:0]         pc,          // program counter
    output logic [7:0]          accum,       // accumulator
    output cpd_status_t         status,      // status flags
    output logic [15:0]         fsr0,        // pointer register 0
    output logic [15:0]         fsr1,        // pointer register 1
    output logic [7:0]          option_cfg,  // timer option configuration
    output logic [PIN_DIRECTION_LOAD_N-1:0][7:0] pin_dir,  // pin direction registers
    output logic                busy,        // extra cycle in progress
    output logic                wdt_clear,   // watchdog clear pulse
    output logic                sleep_req,   // standby entry pulse
    output logic                soft_reset,  // software reset pulse
    output logic                int_return   // interrupt return pulse
);
    localparam int SPW = $clog2(STK_DEPTH);

    logic              q_first;
    logic              q_last;
    cpd_op_t           next_op;
    cpd_op_t           op;
    logic [13:0]       ir;
    logic              exec_ok;
    logic              ind_xtra;
    logic [1:0]        stall;
    logic [1:0]        next_stall;
    logic [15:0]       next_addr;
    logic              next_rd;
    logic              next_st;
    logic              next_xtra;
    logic [15:0]       fsel;
    logic [15:0]       ksext;
    logic [14:0]       stack [STK_DEPTH];
    logic [SPW-1:0]    sp;
    logic [14:0]       pc_inc;
    logic              pc_chg;
    logic              run;
    logic [8:0]        add_sum;
    logic [4:0]        nib_sum;
    logic [7:0]        and_res;
    logic [15:0]       fsr_step;

    cpd_qphase #(.PHASES(QPHASES)) u_qphase (
        .mclk    (mclk),
        .resetn  (resetn),
        .q_first (q_first),
        .q_last  (q_last)
    );

    // decode the word that program memory presents at the cycle start
    always_comb begin
        next_op = OP_OTHER;
        if (instr_word == OPC_NOP) begin
            next_op = OP_NOP;
        end else if (instr_word == OPC_SWRST) begin
            next_op = OP_SWRST;
        end else if (instr_word == OPC_RET) begin
            next_op = OP_RET;
        end else if (instr_word == OPC_RETI) begin
            next_op = OP_RETI;
        end else if (instr_word == OPC_SUBROUTINE_JUMP_BY_ACCUM) begin
            next_op = OP_SUBROUTINE_JUMP_BY_ACCUM;
        end else if (instr_word == OPC_BRW) begin
            next_op = OP_BRW;
        end else if (instr_word == OPC_OPTION) begin
            next_op = OP_OPTION;
        end else if (instr_word == OPC_SLEEP) begin
            next_op = OP_SLEEP;
        end else if (instr_word == OPC_WDTCLR) begin
            next_op = OP_WDTCLR;
        end else if (instr_word[13:3] == PFX_PIN_DIRECTION_LOAD) begin
            next_op = OP_PIN_DIRECTION_LOAD;
        end else if (instr_word[13:4] == PFX_IND) begin
            next_op = OP_IND;
        end else if (instr_word[13:7] == PFX_PADD) begin
            next_op = OP_PADD;
        end else if (instr_word[13:8] == PFX_IDX) begin
            next_op = OP_IDX;
        end else if (instr_word[13:8] == PFX_RETURN_LOADING_LITERAL) begin
            next_op = OP_RETURN_LOADING_LITERAL;
        end else if (instr_word[13:8] == PFX_AND_LITERAL_ACCUM) begin
            next_op = OP_AND_LITERAL_ACCUM;
        end else if (instr_word[13:8] == PFX_ADD_LITERAL_ACCUM) begin
            next_op = OP_ADD_LITERAL_ACCUM;
        end else if (instr_word[13:8] == PFX_AND_ACCUM_FILE) begin
            next_op = OP_AND_ACCUM_FILE;
        end else if (instr_word[13:9] == PFX_BRA) begin
            next_op = OP_BRA;
        end else if (instr_word[13:11] == PFX_CALL) begin
            next_op = OP_CALL;
        end else if (instr_word[13:11] == PFX_GOTO) begin
            next_op = OP_GOTO;
        end
    end

    // data address and the extra-cycle flag for the incoming word
    always_comb begin
        next_addr = {9'h000, instr_word[6:0]};
        next_rd   = 1'b0;
        next_st   = 1'b0;
        next_xtra = 1'b0;
        fsel      = fsr0;
        ksext     = {{10{instr_word[5]}}, instr_word[5:0]};
        unique case (next_op)
            OP_IND: begin
                fsel    = instr_word[2] ? fsr1 : fsr0;
                next_rd = !instr_word[3];
                next_st = instr_word[3];
                unique case (instr_word[1:0])
                    MM_PREINC:  next_addr = fsel + 16'h0001;
                    MM_PREDEC:  next_addr = fsel - 16'h0001;
                    MM_POSTINC: next_addr = fsel;
                    MM_POSTDEC: next_addr = fsel;
                endcase
                next_xtra = fsel[15];
            end
            OP_IDX: begin
                fsel      = instr_word[6] ? fsr1 : fsr0;
                next_addr = fsel + ksext;
                next_rd   = !instr_word[7];
                next_st   = instr_word[7];
                next_xtra = fsel[15];
            end
            OP_AND_ACCUM_FILE: begin
                next_rd = 1'b1;
                if (instr_word[6:0] == FILE_IND0 || instr_word[6:0] == FILE_IND1) begin
                    fsel      = instr_word[0] ? fsr1 : fsr0;
                    next_addr = fsel;
                    next_xtra = fsel[15];
                end
            end
            default: begin
                next_addr = {9'h000, instr_word[6:0]};
            end
        endcase
    end

    // latch the instruction at the cycle start; stall cycles run as no-ops
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            op       <= OP_NOP;
            ir       <= OPC_NOP;
            exec_ok  <= 1'b0;
            ind_xtra <= 1'b0;
        end else if (q_first) begin
            exec_ok  <= (stall == 2'd0);
            op       <= next_op;
            ir       <= instr_word;
            ind_xtra <= next_xtra;
        end
    end

    assign run     = q_last && exec_ok;
    assign pc_inc  = pc + 15'h0001;
    assign pc_chg  = op inside {OP_RET, OP_RETI, OP_SUBROUTINE_JUMP_BY_ACCUM, OP_BRW, OP_RETURN_LOADING_LITERAL,
                                OP_BRA, OP_CALL, OP_GOTO};
    assign add_sum = {1'b0, accum} + {1'b0, ir[7:0]};
    assign nib_sum = {1'b0, accum[3:0]} + {1'b0, ir[3:0]};
    assign and_res = accum & (op == OP_AND_ACCUM_FILE ? mem_rdata : ir[7:0]);
    assign fsr_step = (ir[1:0] == MM_PREINC || ir[1:0] == MM_POSTINC) ? 16'h0001 : 16'hffff;

    // cycle count: one extra for a pc change, one for a high-bit pointer
    always_comb begin
        next_stall = stall;
        if (run) begin
            next_stall = {1'b0, pc_chg} + {1'b0, ind_xtra};
        end else if (q_last && stall != 2'd0) begin
            next_stall = stall - 2'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stall <= 2'd0;
            busy  <= 1'b0;
        end else begin
            stall <= next_stall;
            busy  <= (next_stall != 2'd0);
        end
    end

    // data memory port: reads held for the cycle, writes one clock wide
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mem <= '0;
        end else if (q_first && stall == 2'd0) begin
            mem.addr  <= next_addr;
            mem.wdata <= accum;
            mem.re    <= next_rd;
            mem.we    <= next_st;
        end else if (run && op == OP_AND_ACCUM_FILE && ir[7]) begin
            mem.wdata <= and_res;
            mem.re    <= 1'b0;
            mem.we    <= 1'b1;
        end else if (q_last) begin
            mem.re <= 1'b0;
            mem.we <= 1'b0;
        end else begin
            mem.we <= 1'b0;
        end
    end

    // accumulator and status flags
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            accum  <= ACC_RST;
            status <= STATUS_RST;
        end else if (run) begin
            unique case (op)
                OP_RETURN_LOADING_LITERAL: accum <= ir[7:0];
                OP_AND_LITERAL_ACCUM: begin
                    accum    <= and_res;
                    status.z <= (and_res == 8'h00);
                end
                OP_ADD_LITERAL_ACCUM: begin
                    accum     <= add_sum[7:0];
                    status.c  <= add_sum[8];
                    status.dc <= nib_sum[4];
                    status.z  <= (add_sum[7:0] == 8'h00);
                end
                OP_AND_ACCUM_FILE: begin
                    if (!ir[7]) begin
                        accum <= and_res;
                    end
                    status.z <= (and_res == 8'h00);
                end
                OP_IND, OP_IDX: begin
                    if (op == OP_IND ? !ir[3] : !ir[7]) begin
                        accum    <= mem_rdata;
                        status.z <= (mem_rdata == 8'h00);
                    end
                end
                OP_WDTCLR: begin
                    status.to <= 1'b1;
                    status.pd <= 1'b1;
                end
                OP_SLEEP: begin
                    status.to <= 1'b1;
                    status.pd <= 1'b0;
                end
                default: begin
                    accum <= accum;
                end
            endcase
        end
    end

    // pointer registers; all arithmetic is 16 bits so wrap is free
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fsr0 <= FSR_RST;
            fsr1 <= FSR_RST;
        end else if (run && op == OP_PADD) begin
            if (ir[6]) begin
                fsr1 <= fsr1 + {{10{ir[5]}}, ir[5:0]};
            end else begin
                fsr0 <= fsr0 + {{10{ir[5]}}, ir[5:0]};
            end
        end else if (run && op == OP_IND) begin
            if (ir[2]) begin
                fsr1 <= fsr1 + fsr_step;
            end else begin
                fsr0 <= fsr0 + fsr_step;
            end
        end
    end

    // program counter and return stack; the stack pointer simply wraps
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pc <= PC_RST;
            sp <= '0;
        end else if (run) begin
            unique case (op)
                OP_BRW: pc <= pc_inc + {7'h00, accum};
                OP_BRA: pc <= pc_inc + {{6{ir[8]}}, ir[8:0]};
                OP_GOTO: pc <= {pc_upper_in[6:3], ir[10:0]};
                OP_CALL, OP_SUBROUTINE_JUMP_BY_ACCUM: begin
                    stack[sp] <= pc_inc;
                    sp        <= sp + SPW'(1);
                    pc        <= (op == OP_CALL) ? {pc_upper_in[6:3], ir[10:0]}
                                                 : {pc_upper_in, accum};
                end
                OP_RET, OP_RETI, OP_RETURN_LOADING_LITERAL: begin
                    sp <= sp - SPW'(1);
                    pc <= stack[sp - SPW'(1)];
                end
                default: pc <= pc_inc;
            endcase
        end
    end

    // option and pin direction loads
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            option_cfg <= OPTION_RST;
            pin_dir    <= {PIN_DIRECTION_LOAD_N{PIN_DIRECTION_LOAD_RST}};
        end else if (run && op == OP_OPTION) begin
            option_cfg <= accum;
        end else if (run && op == OP_PIN_DIRECTION_LOAD) begin
            pin_dir[ir[2:0]] <= accum;
        end
    end

    // one-clock event pulses toward the watchdog, power, reset and interrupt logic
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wdt_clear  <= 1'b0;
            sleep_req  <= 1'b0;
            soft_reset <= 1'b0;
            int_return <= 1'b0;
        end else begin
            wdt_clear  <= run && op == OP_WDTCLR;
            sleep_req  <= run && op == OP_SLEEP;
            soft_reset <= run && op == OP_SWRST;
            int_return <= run && op == OP_RETI;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_pcchg_busy;
        run && pc_chg |=> busy [*4] ##1 !busy;
    endproperty
    a_pcchg_busy: assert property (p_pcchg_busy) else $error("pc change not two cycles");

    property p_ind_extra;
        run && op == OP_IDX && ind_xtra |=> busy;
    endproperty
    a_ind_extra: assert property (p_ind_extra) else $error("no extra indirect cycle");

    property p_brw;
        run && op == OP_BRW |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(accum)};
    endproperty
    a_brw: assert property (p_brw) else $error("accumulator branch target wrong");

    property p_return_loading_literal;
        run && op == OP_RETURN_LOADING_LITERAL |=> accum == $past(ir[7:0]);
    endproperty
    a_return_loading_literal: assert property (p_return_loading_literal) else $error("literal not returned");

    property p_wdtclr;
        run && op == OP_WDTCLR |=> wdt_clear && status.to && status.pd ##1 !wdt_clear;
    endproperty
    a_wdtclr: assert property (p_wdtclr) else $error("watchdog clear wrong");

    property p_sleep;
        run && op == OP_SLEEP |=> sleep_req && status.to && !status.pd;
    endproperty
    a_sleep: assert property (p_sleep) else $error("standby entry wrong");

    property p_padd;
        run && op == OP_PADD && !ir[6]
            |=> fsr0 == $past(fsr0) + {{10{$past(ir[5])}}, $past(ir[5:0])} && $stable(status);
    endproperty
    a_padd: assert property (p_padd) else $error("pointer add wrong");

    property p_and_literal_accum;
        run && op == OP_AND_LITERAL_ACCUM |=> accum == ($past(accum) & $past(ir[7:0]));
    endproperty
    a_and_literal_accum: assert property (p_and_literal_accum) else $error("literal and wrong");

    property p_nop;
        run && op == OP_NOP |=> $stable(accum) && $stable(status) && !busy;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    property p_swrst;
        run && op == OP_SWRST |=> soft_reset;
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset missing");
endmodule
`default_nettype wire

// ==== test/test_cpd_core.sv ====
// self-checking bench for the control and pointer decoder
`timescale 1ns/1ns
`default_nettype none
module test_cpd_core import cpd_pkg::*; ;
    logic            mclk = 1'b0;
    logic            resetn = 1'b0;
    logic [13:0]     instr_word = 14'h0;
    logic [6:0]      pc_upper_in = 7'h12;
    logic [7:0]      mem_rdata = 8'h0;
    cpd_mem_req_t    mem;
    logic [14:0]     pc, p0, ret;
    logic [7:0]      accum, option_cfg, we_data, rd;
    cpd_status_t     status;
    logic [15:0]     fsr0, fsr1, re_addr, we_addr, e1, nf, a;
    logic [7:0][7:0] pin_dir;
    logic            busy, wdt_clear, sleep_req, soft_reset, int_return;
    logic [1:0]      ph = 2'h0;
    int              n_errors = 0;
    int              checked = 0;
    int              cyc = 0;
    logic [2:0]      sel [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};

    cpd_core dut_u (
        .mclk(mclk), .resetn(resetn), .instr_word(instr_word),
        .pc_upper_in(pc_upper_in), .mem_rdata(mem_rdata), .mem(mem), .pc(pc),
        .accum(accum), .status(status), .fsr0(fsr0), .fsr1(fsr1),
        .option_cfg(option_cfg), .pin_dir(pin_dir), .busy(busy),
        .wdt_clear(wdt_clear), .sleep_req(sleep_req), .soft_reset(soft_reset),
        .int_return(int_return)
    );

    always #2 mclk = ~mclk;

    // mirrors the hidden divider: after an edge, ph is the phase of the next edge
    always @(posedge mclk) begin
        ph <= resetn ? ph + 2'h1 : 2'h0;
        cyc <= cyc + 1;
        if (mem.re === 1'b1) re_addr <= mem.addr;
        if (mem.we === 1'b1) begin
            we_addr <= mem.addr;
            we_data <= mem.wdata;
        end
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude;
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // word is presented for its own phase-0 edge only; fillers are no-ops
    task automatic exec(input logic [13:0] w, input logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!(ph == 2'h3 && busy === 1'b0) && n < 40);
        @(posedge mclk);
        instr_word <= w;
        mem_rdata <= d;
        @(negedge mclk);
        p0 = pc;
        @(posedge mclk);
        instr_word <= OPC_NOP;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic alu(input logic [13:0] w, input logic [7:0] acc, input logic [4:0] s);
        exec(w, 8'h00);
        chk(accum, acc);
        chk(status, s);
        chk(pc, p0 + 15'h1);
    endtask

    task automatic t_literal;
        alu({PFX_ADD_LITERAL_ACCUM, 8'h0f}, 8'h0f, 5'h18);
        alu({PFX_ADD_LITERAL_ACCUM, 8'h01}, 8'h10, 5'h1a);
        alu({PFX_ADD_LITERAL_ACCUM, 8'hf0}, 8'h00, 5'h1d);
        alu({PFX_ADD_LITERAL_ACCUM, 8'h3c}, 8'h3c, 5'h18);
        alu({PFX_AND_LITERAL_ACCUM, 8'h0f}, 8'h0c, 5'h18);
        alu({PFX_AND_LITERAL_ACCUM, 8'h30}, 8'h00, 5'h1c);
        alu(OPC_NOP, 8'h00, 5'h1c);
    endtask

    task automatic t_flow;
        alu({PFX_ADD_LITERAL_ACCUM, 8'h05}, 8'h05, 5'h18);
        exec(OPC_BRW, 8'h00);
        chk(pc, p0 + 15'h6);
        chk(busy, 1'b1);
        exec(OPC_SUBROUTINE_JUMP_BY_ACCUM, 8'h00);
        chk(pc, 15'h1205);
        ret = p0 + 15'h1;
        exec(OPC_RET, 8'h00);
        chk(pc, ret);
        exec({PFX_GOTO, 11'h123}, 8'h00);
        chk(pc, 15'h1123);
        exec({PFX_CALL, 11'h200}, 8'h00);
        chk(pc, 15'h1200);
        ret = p0 + 15'h1;
        exec({PFX_RETURN_LOADING_LITERAL, 8'h5a}, 8'h00);
        chk(pc, ret);
        chk(accum, 8'h5a);
        exec({PFX_CALL, 11'h010}, 8'h00);
        ret = p0 + 15'h1;
        exec(OPC_RETI, 8'h00);
        chk(pc, ret);
        chk(int_return, 1'b1);
        exec({PFX_BRA, 9'h1fe}, 8'h00);
        chk(pc, p0 - 15'h1);
        chk(busy, 1'b1);
    endtask

    task automatic t_inherent;
        alu({PFX_AND_LITERAL_ACCUM, 8'h00}, 8'h00, 5'h1c);
        alu({PFX_ADD_LITERAL_ACCUM, 8'ha5}, 8'ha5, 5'h18);
        exec(OPC_SLEEP, 8'h00);
        chk(sleep_req, 1'b1);
        chk({status.to, status.pd}, 2'b10);
        exec(OPC_WDTCLR, 8'h00);
        chk(wdt_clear, 1'b1);
        chk({status.to, status.pd}, 2'b11);
        exec(OPC_SWRST, 8'h00);
        chk(soft_reset, 1'b1);
        exec(OPC_OPTION, 8'h00);
        chk(option_cfg, 8'ha5);
        foreach (sel[i]) begin
            exec({PFX_PIN_DIRECTION_LOAD, sel[i]}, 8'h00);
            chk(pin_dir[sel[i]], 8'ha5);
        end
        chk(pin_dir[2], PIN_DIRECTION_LOAD_RST);
    endtask

    task automatic t_pointer;
        alu({PFX_AND_LITERAL_ACCUM, 8'h00}, 8'h00, 5'h1c);
        exec({PFX_PADD, 1'b0, 6'h3f}, 8'h00);
        chk(fsr0, 16'hffff);
        chk(status, 5'h1c);
        exec({PFX_PADD, 1'b0, 6'h01}, 8'h00);
        chk(fsr0, 16'h0000);
        exec({PFX_PADD, 1'b0, 6'h20}, 8'h00);
        chk(fsr0, 16'hffe0);
        exec({PFX_PADD, 1'b1, 6'h1f}, 8'h00);
        chk(fsr1, 16'h001f);
        e1 = 16'h001f;
        // loads with each update mode, then stores with each
        for (int m = 0; m < 8; m++) begin
            nf = m[0] ? e1 - 16'h1 : e1 + 16'h1;
            a = m[1] ? e1 : nf;
            rd = {6'h0, m[1:0]};
            exec({PFX_IND, m[2], 1'b1, m[1:0]}, rd);
            e1 = nf;
            chk(fsr1, e1);
            chk(m < 4 ? re_addr : we_addr, a);
            chk(m < 4 ? accum : we_data, m < 4 ? rd : 8'h03);
            chk(status, m == 0 ? 5'h1c : 5'h18);
        end
        exec({PFX_IDX, 1'b0, 1'b1, 6'h05}, 8'h00);
        chk(re_addr, 16'h0024);
        chk(status, 5'h1c);
        alu({PFX_ADD_LITERAL_ACCUM, 8'h3c}, 8'h3c, 5'h18);
        exec({PFX_IDX, 1'b1, 1'b1, 6'h05}, 8'h00);
        chk(we_addr, 16'h0024);
        chk(we_data, 8'h3c);
        chk(status, 5'h18);
        exec({PFX_IDX, 1'b0, 1'b0, 6'h00}, 8'h11);
        chk(busy, 1'b1);
    endtask

    task automatic t_and_accum_file;
        exec({PFX_AND_ACCUM_FILE, 1'b1, 7'h20}, 8'h0f);
        @(posedge mclk);
        @(negedge mclk);
        chk(we_addr, 16'h0020);
        chk(we_data, 8'h01);
        chk(accum, 8'h11);
        alu({PFX_AND_LITERAL_ACCUM, 8'hff}, 8'h11, 5'h18);
        alu({PFX_AND_ACCUM_FILE, 1'b0, 7'h20}, 8'h00, 5'h1c);
    endtask

    initial begin
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        chk(pc, PC_RST);
        chk(status, STATUS_RST);
        chk(fsr1, FSR_RST);
        chk(option_cfg, OPTION_RST);
        chk(busy, 1'b0);
        @(posedge mclk);
        resetn <= 1'b1;
        t_literal();
        t_flow();
        t_inherent();
        t_pointer();
        t_and_accum_file();
        conclude();
    end
endmodule
`default_nettype wire
